// ===== sae_line_source.sv
`timescale 1ns/100ps
`default_nettype none
module sae_line_source (
  input  wire logic       clock,
  input  wire logic       run,
  input  wire logic [7:0] period,
  input  wire logic [7:0] high_time,
  output logic            line
);
  logic [7:0] cnt_reg;
  always_ff @(posedge clock)
  begin
    if (!run || cnt_reg >= period - 8'h01)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_reg + 8'h01;
  end
  // Held low when stopped, as the pin has no pull-up to fall back on
  assign line = run && (cnt_reg < high_time);
endmodule // sae_line_source
`default_nettype wire

// ===== sae_rec_mem.v
`timescale 1ns/100ps
`default_nettype none
module sae_rec_mem #(
  parameter W     = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          clock,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [W-1:0]  wdata,
  input  wire [AW-1:0] raddr,
  output reg  [W-1:0]  rdata
);
  reg [W-1:0] mem [0:DEPTH-1];

  // No reset on the array; the counter memory's caller tracks valid entries in cnt_valid_reg, the setup memory's caller does not
  always @(posedge clock)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule // sae_rec_mem
`default_nettype wire

// ===== sae_regs.vh
`ifndef SAE_REGS_VH
`define SAE_REGS_VH
`define SAE_CLK_NS        100
`define SAE_SCRAP_TMO_US  100000
`define SAE_SEED_STEP_US  10
`define SAE_LINE_PMIN_US  900
`define SAE_LINE_PMAX_US  1100
`define SAE_LINE_HMIN_US  400
`define SAE_LINE_HMAX_US  600
`define SAE_KEY_MASK      8'h55
`define SAE_HANDSHAKES    2'h2
`define SAE_LINE_GOOD     2'h3
`define SAE_LINE_BAD      2'h2
`define SAE_ST_SCRAP      2'h1
`define SAE_ST_ARMING     2'h2
`endif

// ===== sae_safing_engine.v
`timescale 1ns/100ps
`default_nettype none
`include "sae_regs.vh"
module sae_safing_engine #(
  parameter RECS  = 16,
  parameter RW    = 4,
  parameter CW    = 8,
  parameter DW    = 16,
  parameter LOOPS = 8,
  parameter SCRAP_TMO_CYC = `SAE_SCRAP_TMO_US * 1000 / `SAE_CLK_NS,
  parameter SEED_STEP_CYC = `SAE_SEED_STEP_US * 1000 / `SAE_CLK_NS,
  parameter LINE_PMIN_CYC = (`SAE_LINE_PMIN_US * 1000 + `SAE_CLK_NS - 1) / `SAE_CLK_NS,
  parameter LINE_PMAX_CYC = `SAE_LINE_PMAX_US * 1000 / `SAE_CLK_NS,
  parameter LINE_HMIN_CYC = (`SAE_LINE_HMIN_US * 1000 + `SAE_CLK_NS - 1) / `SAE_CLK_NS,
  parameter LINE_HMAX_CYC = `SAE_LINE_HMAX_US * 1000 / `SAE_CLK_NS
) (
  input  wire              clock,
  input  wire              rst_b,
  input  wire              ssm_reset,
  input  wire              safing_state,
  input  wire              diag_state,
  input  wire              scrap_state,
  input  wire              sample_valid,
  input  wire [RW-1:0]     sample_record,
  input  wire [15:0]       sample_data,
  output reg               sample_ready,
  input  wire              cfg_we,
  input  wire [RW-1:0]     cfg_record,
  input  wire [15:0]       cfg_sample_limit,
  input  wire [DW-1:0]     cfg_dwell,
  input  wire [RECS-1:0]   record_enable,
  input  wire [2*RECS-1:0] record_arm_select,
  input  wire [CW-1:0]     event_increment,
  input  wire [CW-1:0]     event_decrement,
  input  wire [CW-1:0]     positive_arming_limit,
  input  wire [CW-1:0]     negative_arming_limit,
  input  wire              completion_read,
  output reg  [RECS-1:0]   record_completion_bits,
  input  wire [4*LOOPS-1:0] loop_mask,
  output reg  [LOOPS-1:0]  loop_enable,
  output reg  [3:0]        arm_request_out,
  output reg  [3:0]        stretch_timer_status,
  output reg               safing_rail,
  input  wire              hs_fet_cmd,
  output reg               hs_fet_on,
  input  wire              diag_arm_test,
  input  wire [3:0]        diag_arm_pattern,
  input  wire              diag_rail_test,
  input  wire              seed_read,
  output reg  [7:0]        seed_out,
  input  wire              key_valid,
  input  wire [7:0]        key_data,
  input  wire              disposal_line_input,
  output reg               line_qualified,
  output reg               disposal_armed
);
  reg rst_meta_reg, rst_sync_reg;
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_sync_b = rst_sync_reg;

  // Disposal line is an external pin
  reg line_meta_reg, line_sync_reg, line_prev_reg;

  reg              p1_reg;
  reg [RW-1:0]     p1_rec_reg;
  reg [15:0]       p1_data_reg;
  reg [RECS-1:0]   cnt_valid_reg;
  reg [RECS-1:0]   pos_flag_reg;
  reg [RECS-1:0]   neg_flag_reg;
  reg              safing_prev_reg;
  reg [DW-1:0]     dwell_reg [0:3];
  wire [2*CW-1:0]  cnt_rdata;
  wire [15+DW:0]   cfg_rdata;

  // Records with a pending completion bit are skipped entirely
  wire accept = sample_valid & sample_ready & safing_state & ~ssm_reset
              & record_enable[sample_record] & ~record_completion_bits[sample_record];

  wire signed [16:0] samp  = {p1_data_reg[15], p1_data_reg};
  wire signed [16:0] lim   = {cfg_rdata[15+DW], cfg_rdata[15+DW:DW]};
  wire [DW-1:0]      dwell = cfg_rdata[DW-1:0];
  wire pos_evt = samp > lim;
  wire neg_evt = samp < -lim;
  wire [CW-1:0] pos_cur = cnt_valid_reg[p1_rec_reg] ? cnt_rdata[2*CW-1:CW] : {CW{1'b0}};
  wire [CW-1:0] neg_cur = cnt_valid_reg[p1_rec_reg] ? cnt_rdata[CW-1:0] : {CW{1'b0}};
  wire [CW:0] pos_add = {1'b0, pos_cur} + {1'b0, event_increment};
  wire [CW:0] neg_add = {1'b0, neg_cur} + {1'b0, event_increment};
  wire [CW:0] pos_sub = {1'b0, pos_cur} - {1'b0, event_decrement};
  wire [CW:0] neg_sub = {1'b0, neg_cur} - {1'b0, event_decrement};
  // Extra carry bit catches overflow and underflow for saturation
  wire [CW-1:0] pos_new = pos_evt ? (pos_add[CW] ? {CW{1'b1}} : pos_add[CW-1:0])
                                  : (pos_sub[CW] ? {CW{1'b0}} : pos_sub[CW-1:0]);
  wire [CW-1:0] neg_new = neg_evt ? (neg_add[CW] ? {CW{1'b1}} : neg_add[CW-1:0])
                                  : (neg_sub[CW] ? {CW{1'b0}} : neg_sub[CW-1:0]);
  wire pos_arm = pos_new >= positive_arming_limit;
  wire neg_arm = neg_new >= negative_arming_limit;
  wire [1:0] p1_sel = record_arm_select[2*p1_rec_reg +: 2];

  sae_rec_mem #(.W(2*CW), .DEPTH(RECS), .AW(RW)) u_cnt_mem (
    .clock (clock),
    .we    (p1_reg),
    .waddr (p1_rec_reg),
    .wdata ({pos_new, neg_new}),
    .raddr (sample_record),
    .rdata (cnt_rdata)
  );

  // Record setup only changes in the diagnostic state
  sae_rec_mem #(.W(16+DW), .DEPTH(RECS), .AW(RW)) u_cfg_mem (
    .clock (clock),
    .we    (cfg_we & diag_state),
    .waddr (cfg_record),
    .wdata ({cfg_sample_limit, cfg_dwell}),
    .raddr (sample_record),
    .rdata (cfg_rdata)
  );

  wire safing_entry = safing_state & ~safing_prev_reg;
  wire [RECS-1:0] rec_armed = record_enable & (pos_flag_reg | neg_flag_reg);
  wire [4*RECS-1:0] rec_on_arm;
  wire [3:0] int_arm;
  wire [3:0] dwell_run;
  genvar g, a;
  generate
    for (a = 0; a < 4; a = a + 1)
    begin : g_arm
      for (g = 0; g < RECS; g = g + 1)
      begin : g_rec
        assign rec_on_arm[a*RECS+g] = rec_armed[g] & (record_arm_select[2*g +: 2] == a);
      end
      assign int_arm[a]   = |rec_on_arm[a*RECS +: RECS];
      assign dwell_run[a] = |dwell_reg[a];
    end
  endgenerate

  always @(posedge clock or negedge rst_sync_b)
  begin : p_engine
    integer i;
    if (!rst_sync_b)
    begin
      p1_reg                 <= 1'b0;
      p1_rec_reg             <= {RW{1'b0}};
      p1_data_reg            <= 16'h0000;
      sample_ready           <= 1'b0;
      cnt_valid_reg          <= {RECS{1'b0}};
      pos_flag_reg           <= {RECS{1'b0}};
      neg_flag_reg           <= {RECS{1'b0}};
      record_completion_bits <= {RECS{1'b0}};
      safing_prev_reg        <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        dwell_reg[i] <= {DW{1'b0}};
    end
    else if (ssm_reset)
    begin
      // Reset clears records and truncates running dwell
      p1_reg                 <= 1'b0;
      sample_ready           <= 1'b0;
      cnt_valid_reg          <= {RECS{1'b0}};
      pos_flag_reg           <= {RECS{1'b0}};
      neg_flag_reg           <= {RECS{1'b0}};
      record_completion_bits <= {RECS{1'b0}};
      safing_prev_reg        <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        dwell_reg[i] <= {DW{1'b0}};
    end
    else
    begin
      p1_reg          <= accept;
      p1_rec_reg      <= sample_record;
      p1_data_reg     <= sample_data;
      sample_ready    <= ~accept; // One sample in flight avoids a read-after-write hazard
      safing_prev_reg <= safing_state;
      if (safing_entry)
      begin
        for (i = 0; i < RECS; i = i + 1)
        begin
          if (positive_arming_limit == {CW{1'b0}})
            pos_flag_reg[i] <= 1'b1;
          if (negative_arming_limit == {CW{1'b0}})
            neg_flag_reg[i] <= 1'b1;
        end
      end
      for (i = 0; i < 4; i = i + 1)
        if (dwell_run[i])
          dwell_reg[i] <= dwell_reg[i] - 1'b1;
      // Completion set wins over a read in the same cycle
      if (completion_read)
        record_completion_bits <= {RECS{1'b0}};
      if (p1_reg)
      begin
        cnt_valid_reg[p1_rec_reg]          <= 1'b1;
        pos_flag_reg[p1_rec_reg]           <= pos_arm;
        neg_flag_reg[p1_rec_reg]           <= neg_arm;
        record_completion_bits[p1_rec_reg] <= 1'b1;
        if ((pos_arm | neg_arm) && dwell > dwell_reg[p1_sel])
          dwell_reg[p1_sel] <= dwell;
      end
    end
  end

  // Disposal: seed, key handshake, line qualification
  reg [7:0]  seed_cnt_reg;
  reg [31:0] seed_div_reg;
  reg [7:0]  exp_key_reg;
  reg [1:0]  hs_cnt_reg;
  reg [1:0]  scrap_st_reg;
  reg [31:0] tmo_reg;
  reg [31:0] per_reg;
  reg [31:0] high_reg;
  reg [1:0]  good_reg;
  reg [1:0]  bad_reg;

  wire line_rise  = line_sync_reg & ~line_prev_reg;
  wire per_over   = per_reg >= LINE_PMAX_CYC;
  wire cyc_end    = line_rise | per_over;
  wire cyc_ok     = line_rise && per_reg >= LINE_PMIN_CYC
                 && high_reg >= LINE_HMIN_CYC && high_reg <= LINE_HMAX_CYC;
  wire key_ok     = key_valid & (key_data == exp_key_reg);
  wire in_arming  = scrap_st_reg == `SAE_ST_ARMING;
  wire tmo_hit    = tmo_reg == 32'h00000000;

  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      line_meta_reg  <= 1'b0;
      line_sync_reg  <= 1'b0;
      line_prev_reg  <= 1'b0;
      seed_cnt_reg   <= 8'h00;
      seed_div_reg   <= 32'h00000000;
      seed_out       <= 8'h00;
      exp_key_reg    <= `SAE_KEY_MASK;
      hs_cnt_reg     <= 2'h0;
      scrap_st_reg   <= `SAE_ST_SCRAP;
      tmo_reg        <= 32'h00000000;
      per_reg        <= 32'h00000000;
      high_reg       <= 32'h00000000;
      good_reg       <= 2'h0;
      bad_reg        <= 2'h0;
      line_qualified <= 1'b0;
    end
    else
    begin
      line_meta_reg <= disposal_line_input;
      line_sync_reg <= line_meta_reg;
      line_prev_reg <= line_sync_reg;
      if (seed_div_reg >= SEED_STEP_CYC - 1)
      begin
        seed_div_reg <= 32'h00000000;
        seed_cnt_reg <= seed_cnt_reg + 8'h01;
      end
      else
        seed_div_reg <= seed_div_reg + 32'h00000001;
      if (seed_read)
      begin
        seed_out    <= seed_cnt_reg;
        exp_key_reg <= seed_cnt_reg ^ `SAE_KEY_MASK;
      end
      // Line timing; a stuck line counts as an invalid cycle
      per_reg  <= cyc_end ? 32'h00000001 : per_reg + 32'h00000001;
      high_reg <= cyc_end ? {31'h0, line_sync_reg} : high_reg + {31'h0, line_sync_reg};
      if (cyc_end)
      begin
        if (cyc_ok)
        begin
          bad_reg <= 2'h0;
          if (good_reg != `SAE_LINE_GOOD)
            good_reg <= good_reg + 2'h1;
          if (good_reg + 2'h1 == `SAE_LINE_GOOD)
            line_qualified <= 1'b1;
        end
        else
        begin
          good_reg <= 2'h0;
          if (bad_reg != `SAE_LINE_BAD)
            bad_reg <= bad_reg + 2'h1;
          if (bad_reg + 2'h1 == `SAE_LINE_BAD)
            line_qualified <= 1'b0;
        end
      end
      if (!in_arming || key_ok)
        tmo_reg <= SCRAP_TMO_CYC;
      else if (!tmo_hit)
        tmo_reg <= tmo_reg - 32'h00000001;
      case (scrap_st_reg)
        `SAE_ST_SCRAP:
        begin
          if (key_valid)
            hs_cnt_reg <= key_ok ? ((hs_cnt_reg == `SAE_HANDSHAKES) ? hs_cnt_reg
                                                                   : hs_cnt_reg + 2'h1)
                                 : 2'h0;
          if (scrap_state && hs_cnt_reg == `SAE_HANDSHAKES && line_qualified)
            scrap_st_reg <= `SAE_ST_ARMING;
        end
        `SAE_ST_ARMING:
        begin
          if (!scrap_state || (key_valid && !key_ok) || tmo_hit || !line_qualified)
          begin
            scrap_st_reg <= `SAE_ST_SCRAP;
            hs_cnt_reg   <= 2'h0;
          end
        end
        default:
          scrap_st_reg <= `SAE_ST_SCRAP;
      endcase
    end
  end

  // Output stage
  wire [3:0] req_now = int_arm | dwell_run;
  wire arm_test  = diag_state & diag_arm_test;
  wire rail_test = diag_state & diag_rail_test & ~diag_arm_test;
  reg  [3:0] arm_next;
  always @*
  begin
    if (ssm_reset)
      arm_next = 4'h0;
    else if (in_arming)
      arm_next = 4'hF;
    else if (arm_test)
      arm_next = diag_arm_pattern;
    else if (safing_state)
      arm_next = req_now;
    else
      arm_next = dwell_run;
  end

  wire [LOOPS-1:0] loop_next;
  generate
    for (g = 0; g < LOOPS; g = g + 1)
    begin : g_loop
      assign loop_next[g] = |(arm_next & ~loop_mask[4*g +: 4]);
    end
  endgenerate

  wire rail_next = ~ssm_reset & ((|arm_next & ~arm_test) | rail_test);

  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      arm_request_out      <= 4'h0;
      stretch_timer_status <= 4'h0;
      loop_enable          <= {LOOPS{1'b0}};
      safing_rail          <= 1'b0;
      hs_fet_on            <= 1'b0;
      disposal_armed       <= 1'b0;
    end
    else
    begin
      arm_request_out      <= arm_next;
      // Reset truncates dwell at once, so status must not lag it by a cycle
      stretch_timer_status <= ssm_reset ? 4'h0 : dwell_run;
      loop_enable          <= loop_next;
      safing_rail          <= rail_next;
      hs_fet_on            <= rail_next & hs_fet_cmd;
      disposal_armed       <= in_arming;
    end
  end
endmodule // sae_safing_engine
`default_nettype wire

// ===== sae_safing_engine_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module sae_safing_monitor #(
  parameter RECS = 16,
  parameter RW   = 4
) (
  input wire logic            clock,
  input wire logic            rst_b,
  input wire logic            ssm_reset,
  input wire logic            safing_state,
  input wire logic            diag_state,
  input wire logic            scrap_state,
  input wire logic            sample_valid,
  input wire logic [RW-1:0]   sample_record,
  input wire logic            sample_ready,
  input wire logic [RECS-1:0] record_enable,
  input wire logic            completion_read,
  input wire logic [RECS-1:0] record_completion_bits,
  input wire logic [3:0]      arm_request_out,
  input wire logic [3:0]      stretch_timer_status,
  input wire logic            safing_rail,
  input wire logic            hs_fet_cmd,
  input wire logic            hs_fet_on,
  input wire logic            seed_read,
  input wire logic [7:0]      seed_out,
  input wire logic            line_qualified,
  input wire logic            disposal_armed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    sample_valid && sample_ready && safing_state && !ssm_reset
      && record_enable[sample_record] && !record_completion_bits[sample_record];
  endsequence
  sequence s_bit_set;
    (record_completion_bits & ~$past(record_completion_bits)) != '0;
  endsequence
  take_gap_a: assert property (s_take |=> !sample_ready)
    else $error("sample taken without ready dropping");
  bit_cause_a: assert property (s_bit_set |-> $past(sample_valid, 2) && $past(safing_state, 2))
    else $error("completion bit set without a sample in safing");
  read_clear_a: assert property (completion_read && sample_ready && !ssm_reset |=> record_completion_bits == '0)
    else $error("completion read left bits set");
  ssm_idle_a: assert property (ssm_reset && !diag_state && !scrap_state |=> arm_request_out == 4'h0 && stretch_timer_status == 4'h0 && record_completion_bits == '0)
    else $error("safing reset left the engine active");
  fet_cmd_a: assert property (!hs_fet_cmd |=> !hs_fet_on)
    else $error("safing switch on without command");
  seed_hold_a: assert property (!seed_read |=> $stable(seed_out))
    else $error("seed changed without a seed read");
  arm_all_a: assert property (disposal_armed |-> arm_request_out == 4'hF && safing_rail)
    else $error("arming state without all outputs");
  arm_cause_a: assert property ($rose(disposal_armed) |-> $past(line_qualified, 2) && $past(scrap_state, 2))
    else $error("arming entered without qualified line");
  line_drop_a: assert property ($fell(line_qualified) |-> ##[0:2] !disposal_armed)
    else $error("arming kept after line lost");
  scrap_leave_a: assert property (!scrap_state [*3] |-> !disposal_armed)
    else $error("arming kept outside scrap");
endmodule // sae_safing_monitor
bind sae_safing_engine sae_safing_monitor #(.RECS(RECS), .RW(RW)) i_sae_safing_monitor (
  .clock, .rst_b, .ssm_reset, .safing_state, .diag_state, .scrap_state, .sample_valid,
  .sample_record, .sample_ready, .record_enable, .completion_read, .record_completion_bits,
  .arm_request_out, .stretch_timer_status, .safing_rail, .hs_fet_cmd, .hs_fet_on,
  .seed_read, .seed_out, .line_qualified, .disposal_armed);
`default_nettype wire

// ===== tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock = 1'b0, rst_b = 1'b0, ssm_reset = 1'b0, safing_state = 1'b0;
  logic diag_state = 1'b0, scrap_state = 1'b0, sample_valid = 1'b0, cfg_we = 1'b0;
  logic completion_read = 1'b0, hs_fet_cmd = 1'b0, diag_arm_test = 1'b0;
  logic diag_rail_test = 1'b0, seed_read = 1'b0, key_valid = 1'b0, run = 1'b0;
  logic [3:0] sample_record = 4'h0, cfg_record = 4'h0, diag_arm_pattern = 4'h0;
  logic [15:0] sample_data = 16'h0000, cfg_sample_limit = 16'h0000, cfg_dwell = 16'h0000;
  logic [15:0] record_enable = 16'h0003;
  // Record 1 on signal 1; loop 0 takes signal 0, loop 1 signal 1, the rest masked
  logic [31:0] record_arm_select = 32'h00000004, loop_mask = 32'hFFFFFFDE;
  logic [7:0] event_increment = 8'h02, event_decrement = 8'h01;
  logic [7:0] positive_arming_limit = 8'h04, negative_arming_limit = 8'h04;
  logic [7:0] key_data = 8'h00, period = 8'h14, high_time = 8'h0A, seed_out, loop_enable;
  logic [15:0] record_completion_bits;
  logic [3:0] arm_request_out, stretch_timer_status;
  logic sample_ready, safing_rail, hs_fet_on, line_qualified, disposal_armed;
  logic disposal_line_input;
  int error_cnt = 0;
  int checks = 0;
  always #50 clock = ~clock;
  sae_safing_engine #(.SCRAP_TMO_CYC(200), .SEED_STEP_CYC(4), .LINE_PMIN_CYC(18),
    .LINE_PMAX_CYC(22), .LINE_HMIN_CYC(8), .LINE_HMAX_CYC(12)) i_sae_safing_engine (
    .clock, .rst_b, .ssm_reset, .safing_state, .diag_state, .scrap_state, .sample_valid,
    .sample_record, .sample_data, .sample_ready, .cfg_we, .cfg_record, .cfg_sample_limit,
    .cfg_dwell, .record_enable, .record_arm_select, .event_increment, .event_decrement,
    .positive_arming_limit, .negative_arming_limit, .completion_read,
    .record_completion_bits, .loop_mask, .loop_enable, .arm_request_out,
    .stretch_timer_status, .safing_rail, .hs_fet_cmd, .hs_fet_on, .diag_arm_test,
    .diag_arm_pattern, .diag_rail_test, .seed_read, .seed_out, .key_valid, .key_data,
    .disposal_line_input, .line_qualified, .disposal_armed);
  sae_line_source i_sae_line_source (.clock, .run, .period, .high_time,
    .line(disposal_line_input));
  task complete_run;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Bounded wait: 0 ready, 1 line qualified, 2 arming state
  task await(input int sel, input logic v, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      if ((sel == 0 ? sample_ready : sel == 1 ? line_qualified : disposal_armed) === v)
        return;
      @(negedge clock);
    end
    error_cnt++;
    $display("Error wait %0d expected %b seen timeout", sel, v);
    complete_run;
  endtask
  task smp(input logic [3:0] r, input logic [15:0] d);
    await(0, 1'b1, 20);
    sample_valid = 1'b1;
    sample_record = r;
    sample_data = d;
    @(negedge clock);
    sample_valid = 1'b0;
    cyc(3);
  endtask
  task rd;
    completion_read = 1'b1;
    @(negedge clock);
    completion_read = 1'b0;
  endtask
  task cfg(input logic [3:0] r, input logic [15:0] dw);
    cfg_we = 1'b1;
    cfg_record = r;
    cfg_sample_limit = 16'h0064;
    cfg_dwell = dw;
    @(negedge clock);
    cfg_we = 1'b0;
  endtask
  task hs(input logic [7:0] mask);
    seed_read = 1'b1;
    @(negedge clock);
    seed_read = 1'b0;
    cyc(1);
    key_data = seed_out ^ mask;
    key_valid = 1'b1;
    @(negedge clock);
    key_valid = 1'b0;
    cyc(2);
  endtask
  initial
  begin
    cyc(16);
    rst_b = 1'b1;
    cyc(4);
    diag_state = 1'b1;
    cfg(4'h0, 16'h000A);
    cfg(4'h1, 16'h000A);
    diag_arm_test = 1'b1;
    diag_rail_test = 1'b1;
    diag_arm_pattern = 4'hA;
    cyc(3);
    chk("diag_pins", 32'hA, arm_request_out);
    chk("diag_rail", 32'h0, safing_rail);
    diag_arm_test = 1'b0;
    cyc(3);
    chk("diag_rail_alone", 32'h1, safing_rail);
    diag_rail_test = 1'b0;
    diag_state = 1'b0;
    safing_state = 1'b1;
    smp(4'h0, 16'h0000);
    chk("done_bits", 32'h1, record_completion_bits);
    smp(4'h0, 16'h00C8);
    rd;
    smp(4'h0, 16'h00C8);
    chk("one_event", 32'h0, arm_request_out);
    rd;
    smp(4'h0, 16'h0065);
    chk("pos_arm", 32'h1, arm_request_out);
    chk("loops", 32'h01, loop_enable);
    chk("rail", 32'h1, safing_rail);
    chk("fet_off", 32'h0, hs_fet_on);
    hs_fet_cmd = 1'b1;
    cyc(2);
    chk("fet_on", 32'h1, hs_fet_on);
    rd;
    // Exactly at the limit is no event, so this one decrements
    smp(4'h0, 16'h0064);
    record_enable = 16'h0002;
    chk("dwell_pin", 32'h1, arm_request_out);
    chk("dwell_run", 32'h1, stretch_timer_status);
    cyc(15);
    chk("dwell_end", 32'h0, arm_request_out);
    record_enable = 16'h0003;
    rd;
    smp(4'h1, 16'hFF9B);
    rd;
    smp(4'h1, 16'hFF9B);
    chk("neg_arm", 32'h2, arm_request_out);
    chk("neg_loops", 32'h02, loop_enable);
    loop_mask = 32'hFFFFFFFE;
    cyc(1);
    chk("masked_loops", 32'h00, loop_enable);
    ssm_reset = 1'b1;
    safing_state = 1'b0;
    positive_arming_limit = 8'h00;
    cyc(2);
    chk("ssm_idle", 32'h0, arm_request_out);
    ssm_reset = 1'b0;
    safing_state = 1'b1;
    cyc(4);
    chk("zero_limit", 32'h3, arm_request_out);
    positive_arming_limit = 8'h04;
    safing_state = 1'b0;
    ssm_reset = 1'b1;
    cyc(2);
    ssm_reset = 1'b0;
    scrap_state = 1'b1;
    run = 1'b1;
    hs(8'h55);
    hs(8'h55);
    await(1, 1'b1, 200);
    await(2, 1'b1, 50);
    chk("scrap_pins", 32'hF, arm_request_out);
    chk("scrap_rail", 32'h1, safing_rail);
    hs(8'h55);
    chk("kept", 32'h1, disposal_armed);
    hs(8'hAA);
    await(2, 1'b0, 5);
    chk("key_drop", 32'h0, arm_request_out);
    hs(8'h55);
    hs(8'h55);
    await(2, 1'b1, 50);
    cyc(250);
    chk("timeout", 32'h0, disposal_armed);
    // Short high time breaks the duty check; restoring it qualifies again
    high_time = 8'h04;
    await(1, 1'b0, 150);
    high_time = 8'h0A;
    await(1, 1'b1, 200);
    period = 8'h28;
    await(1, 1'b0, 150);
    complete_run;
  end
endmodule // tb
`default_nettype wire
